/* File: logic/aio_pkg.sv */
// Purpose: shared constants for the analog i/o board control logic
// Assumes: 20 MHz clock, byte-wide memory-mapped host bus
// Notes: offsets are relative to the board base address
package aio_pkg;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_CHAN = 4'h1;
  localparam logic [3:0] OFF_LAST = 4'h2;
  localparam logic [3:0] OFF_ICLR = 4'h3;
  localparam logic [3:0] OFF_RES_LO = 4'h4;
  localparam logic [3:0] OFF_RES_HI = 4'h5;
  localparam logic [3:0] OFF_DAC0_LO = 4'h8;
  localparam logic [3:0] OFF_DAC0_HI = 4'h9;
  localparam logic [3:0] OFF_DAC1_LO = 4'hA;
  localparam logic [3:0] OFF_DAC1_HI = 4'hB;
  localparam logic [15:0] BASE_DEFAULT = 16'hF700;
  // control bit positions
  localparam int CTL_EN = 0;
  localparam int CTL_AUTO = 1;
  localparam int CTL_EXT = 2;
  localparam int CTL_CLRBUSY = 3;
  localparam int CTL_EOS_IE = 4;
  localparam int CTL_EOC_IE = 5;
  // status bit positions
  localparam int ST_EN = 0;
  localparam int ST_AUTO = 1;
  localparam int ST_EXT = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_EOS_IE = 4;
  localparam int ST_EOC_IE = 5;
  localparam int ST_EOS = 6;
  localparam int ST_EOC = 7;
  // channel/gain field layout
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 5;
  localparam int GAIN_LSB = 6;
  localparam int GAIN_W = 2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [11:0] RESET_DAC = 12'h000;
  // conversion and pacer timing
  localparam int CLK_HZ = 20000000;
  localparam int CONV_NS = 34000;
  localparam int CONV_CYCLES = (CONV_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int SAMPLE_CYCLES = 4;
  localparam int PACER_BASE_MS = 1000;
  localparam int PACER_BASE_CYCLES = PACER_BASE_MS * (CLK_HZ / 1000);
  localparam int PACER_MAX_N = 10;
endpackage

/* File: logic/pacer_div.sv */
// Purpose: pacer clock, one pulse per 1000/2^n ms
// Assumes: n held stable by jumper
// Notes: count above 4096 so base is a parameter
`timescale 1ns/1ps
module pacer_div #(
  parameter int BASE_CYCLES = aio_pkg::PACER_BASE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [3:0] i_n,
  output logic o_tick
);
  logic [31:0] cnt_q;
  logic [3:0] n_sat;
  logic [31:0] period;
  logic wrap;
  assign n_sat = (i_n > 4'(aio_pkg::PACER_MAX_N)) ? 4'(aio_pkg::PACER_MAX_N) : i_n;
  assign period = 32'(BASE_CYCLES) >> n_sat; // [R9]
  assign wrap = (cnt_q >= period - 32'h1);
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= 32'h0;
      o_tick <= 1'b0;
    end else begin
      cnt_q <= wrap ? 32'h0 : cnt_q + 32'h1;
      o_tick <= wrap;
    end
  end
endmodule

/* File: logic/sar_conv.sv */
// Purpose: sample-and-hold then 12-bit successive approximation sequencer
// Assumes: comparator output valid one cycle after trial drive
// Notes: bit periods spread evenly over the conversion time
`timescale 1ns/1ps
module sar_conv #(
  parameter int CONV_CYCLES = aio_pkg::CONV_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic i_cmp,
  output logic o_hold,
  output logic [11:0] o_trial,
  output logic o_done,
  output logic [11:0] o_result
);
  localparam int BIT_CYC = CONV_CYCLES / 12;
  typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_BITS} sar_state_t;
  sar_state_t st_q;
  logic [15:0] cnt_q;
  logic [3:0] bit_q;
  logic [11:0] mask;
  logic tick;
  assign mask = 12'h1 << bit_q;
  assign tick = (cnt_q == 16'h0);
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= S_IDLE;
      cnt_q <= 16'h0;
      bit_q <= 4'hB;
      o_trial <= 12'h000;
      o_hold <= 1'b0;
      o_done <= 1'b0;
      o_result <= 12'h000;
    end else begin
      o_done <= 1'b0;
      case (st_q)
        S_IDLE: if (i_start) begin
          st_q <= S_SAMPLE; // [R22]
          cnt_q <= 16'(aio_pkg::SAMPLE_CYCLES);
        end
        S_SAMPLE: if (tick) begin
          st_q <= S_BITS;
          o_hold <= 1'b1;
          bit_q <= 4'hB;
          o_trial <= 12'h800;
          cnt_q <= 16'(BIT_CYC - 1);
        end else cnt_q <= cnt_q - 16'h1;
        S_BITS: if (tick) begin
          // keep the trial bit only when the input is at or above it
          if (!i_cmp) o_trial[bit_q] <= 1'b0; // [R22]
          if (bit_q == 4'h0) begin
            st_q <= S_IDLE;
            o_hold <= 1'b0;
            o_done <= 1'b1;
            o_result <= i_cmp ? o_trial : (o_trial & ~mask);
          end else begin
            bit_q <= bit_q - 4'h1;
            o_trial[bit_q - 4'h1] <= 1'b1;
            cnt_q <= 16'(BIT_CYC - 1);
          end
        end else cnt_q <= cnt_q - 16'h1;
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule

/* File: logic/aio_ctrl.sv */
// Purpose: register file and conversion sequencing of the analog i/o board
// Assumes: host cycles are single-clock strobes synchronous to I_CLK
// Notes: read data is registered, valid the cycle after the read strobe
// Contract
// [R1] three modes: repeat one channel, sequential scan, random channel
// [R2] host writes channel register; mux routes that channel onward
// [R3] control register write starts the first conversion
// [R4] reading the result starts the next conversion
// [R5] control bit 1 set enables channel auto-increment scanning
// [R6] host rewrites channel before reading result in random mode
// [R7] starts come from external trigger, pacer or host accesses
// [R8] interrupt on end of conversion or scan; offset 3 clears
// [R9] pacer period is 1000/2^n ms, n jumper 0 to 10
// [R10] dac low nibble held, high byte write loads all 12 bits
// [R11] offset 0 writes control, reads status
// [R12] channel register read/write at offset 1
// [R13] offset 2 write loads the scan last-channel register
// [R14] offsets 4 and 5 read result low and high bytes
// [R15] dac 0 at offsets 8/9, dac 1 at A/B
// [R16] two-bit gain code selects x1, x2, x4, x8
// [R17] five-bit field selects one of 32 channels
// [R18] control holds enables, interrupts and a clear-busy bit
// [R19] status reports eoc, eos, enables and busy
// [R20] decoded as memory at jumper base, default F700H
// [R21] 8/16 inputs, 16/32 with expander multiplexers
// [R22] 34 us successive approximation after sample-and-hold
// [R23] auto-increment advances channel, end of scan at last channel
// [R24] busy from start to latch, eoc when result readable
`timescale 1ns/1ps
module aio_ctrl #(
  parameter int PACER_BASE = aio_pkg::PACER_BASE_CYCLES,
  parameter int CONV_CYC = aio_pkg::CONV_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic [15:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_MWR,
  input wire logic I_MRD,
  input wire logic [15:0] I_BASE,
  input wire logic [3:0] I_PACER_N,
  input wire logic I_EXPANDED,
  input wire logic I_SINGLE_ENDED,
  input wire logic I_EXT_TRIG,
  input wire logic I_CMP,
  output logic [7:0] O_RDATA,
  output logic O_ACK,
  output logic O_INT,
  output logic [4:0] O_MUX_CHAN,
  output logic O_MUX_VALID,
  output logic [1:0] O_GAIN,
  output logic O_HOLD,
  output logic [11:0] O_TRIAL,
  output logic [11:0] O_DAC0,
  output logic [11:0] O_DAC1
);
  logic [7:0] ctrl_q;
  logic [7:0] chan_gain_q;
  logic [7:0] last_q;
  logic [3:0] dac0_lo_q;
  logic [3:0] dac1_lo_q;
  logic [11:0] result_q;
  logic busy_q;
  logic eoc_q;
  logic eos_q;
  logic ext_q;
  logic [4:0] conv_chan_q;
  logic hit;
  logic [3:0] off;
  logic wr_ctrl, wr_chan, wr_last, wr_iclr;
  logic wr_d0lo, wr_d0hi, wr_d1lo, wr_d1hi;
  logic rd_hi;
  logic ext_rise;
  logic pacer_tick;
  logic start;
  logic conv_start;
  logic conv_done;
  logic [11:0] conv_result;
  logic [4:0] chan_max;
  logic [4:0] chan;
  logic [4:0] chan_next;
  logic scan_end;
  logic [7:0] status;
  logic [7:0] rdata_d;

  // memory decode, 16 byte window at the jumper base
  assign hit = (I_ADDR[15:4] == I_BASE[15:4]); // [R20]
  assign off = I_ADDR[3:0];
  assign wr_ctrl = I_MWR && hit && (off == aio_pkg::OFF_CTRL); // [R11]
  assign wr_chan = I_MWR && hit && (off == aio_pkg::OFF_CHAN); // [R12]
  assign wr_last = I_MWR && hit && (off == aio_pkg::OFF_LAST); // [R13]
  assign wr_iclr = I_MWR && hit && (off == aio_pkg::OFF_ICLR); // [R8]
  assign wr_d0lo = I_MWR && hit && (off == aio_pkg::OFF_DAC0_LO); // [R15]
  assign wr_d0hi = I_MWR && hit && (off == aio_pkg::OFF_DAC0_HI); // [R15]
  assign wr_d1lo = I_MWR && hit && (off == aio_pkg::OFF_DAC1_LO); // [R15]
  assign wr_d1hi = I_MWR && hit && (off == aio_pkg::OFF_DAC1_HI); // [R15]
  // the high byte read is the one that retriggers; low byte can be read first
  assign rd_hi = I_MRD && hit && (off == aio_pkg::OFF_RES_HI); // [R4]

  assign chan = chan_gain_q[aio_pkg::CHAN_LSB +: aio_pkg::CHAN_W]; // [R17]
  // fewer physical inputs without expander muxes
  assign chan_max = I_EXPANDED ? (I_SINGLE_ENDED ? 5'h1F : 5'h0F)
                               : (I_SINGLE_ENDED ? 5'h0F : 5'h07); // [R21]
  assign chan_next = (conv_chan_q >= last_q[4:0]) ? 5'h00 : conv_chan_q + 5'h01;
  assign scan_end = ctrl_q[aio_pkg::CTL_AUTO] && (conv_chan_q == last_q[4:0]); // [R23]

  assign ext_rise = I_EXT_TRIG && !ext_q;
  // a start while busy is dropped; the sequencer cannot restart mid-conversion
  assign start = ctrl_q[aio_pkg::CTL_EN] && !busy_q &&
                 (wr_ctrl ? 1'b0 :
                  ctrl_q[aio_pkg::CTL_EXT] ? ext_rise :
                  (pacer_tick || rd_hi)); // [R7]
  // a control write with enable set is the first start
  assign conv_start = start || (wr_ctrl && I_WDATA[aio_pkg::CTL_EN] && !busy_q); // [R3]

  assign status = {eoc_q, eos_q, ctrl_q[aio_pkg::CTL_EOC_IE], ctrl_q[aio_pkg::CTL_EOS_IE],
                   busy_q, ctrl_q[aio_pkg::CTL_EXT], ctrl_q[aio_pkg::CTL_AUTO],
                   ctrl_q[aio_pkg::CTL_EN]}; // [R19]

  always_comb begin
    rdata_d = aio_pkg::RESET_BYTE;
    case (off)
      aio_pkg::OFF_CTRL: rdata_d = status; // [R11]
      aio_pkg::OFF_CHAN: rdata_d = chan_gain_q; // [R12]
      aio_pkg::OFF_RES_LO: rdata_d = {4'h0, result_q[3:0]}; // [R14]
      aio_pkg::OFF_RES_HI: rdata_d = result_q[11:4]; // [R14]
      default: rdata_d = aio_pkg::RESET_BYTE;
    endcase
  end

  pacer_div #(
    .BASE_CYCLES(PACER_BASE)
  ) u_pacer (
    .i_clk(I_CLK),
    .i_resetn(I_RESETN),
    .i_n(I_PACER_N),
    .o_tick(pacer_tick)
  );

  sar_conv #(
    .CONV_CYCLES(CONV_CYC)
  ) u_sar (
    .i_clk(I_CLK),
    .i_resetn(I_RESETN),
    .i_start(conv_start),
    .i_cmp(I_CMP),
    .o_hold(O_HOLD),
    .o_trial(O_TRIAL),
    .o_done(conv_done),
    .o_result(conv_result)
  );

  // host register file
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ctrl_q <= aio_pkg::RESET_BYTE;
      last_q <= aio_pkg::RESET_BYTE;
      dac0_lo_q <= 4'h0;
      dac1_lo_q <= 4'h0;
      O_DAC0 <= aio_pkg::RESET_DAC;
      O_DAC1 <= aio_pkg::RESET_DAC;
      ext_q <= 1'b0;
    end else begin
      ext_q <= I_EXT_TRIG;
      // clear-busy is a command, so it is not kept
      if (wr_ctrl) ctrl_q <= I_WDATA & 8'hF7; // [R3] [R5] [R18]
      if (wr_last) last_q <= I_WDATA; // [R13]
      if (wr_d0lo) dac0_lo_q <= I_WDATA[3:0]; // [R10]
      if (wr_d1lo) dac1_lo_q <= I_WDATA[3:0]; // [R10]
      if (wr_d0hi) O_DAC0 <= {I_WDATA, dac0_lo_q}; // [R10]
      if (wr_d1hi) O_DAC1 <= {I_WDATA, dac1_lo_q}; // [R10]
    end
  end

  // channel select: host write, or auto-advance after each conversion
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      chan_gain_q <= aio_pkg::RESET_BYTE;
    end else if (conv_done && ctrl_q[aio_pkg::CTL_AUTO]) begin
      chan_gain_q[aio_pkg::CHAN_LSB +: aio_pkg::CHAN_W] <= chan_next; // [R1] [R23]
      // the channel field goes to the scan, but the gain write is not lost
      if (wr_chan) begin
        chan_gain_q[aio_pkg::GAIN_LSB +: aio_pkg::GAIN_W] <=
          I_WDATA[aio_pkg::GAIN_LSB +: aio_pkg::GAIN_W]; // [R16]
      end
    end else if (wr_chan) begin
      chan_gain_q <= I_WDATA; // [R2] [R6] [R16]
    end
  end

  // conversion status; hardware set wins over host clear
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      busy_q <= 1'b0;
      eoc_q <= 1'b0;
      eos_q <= 1'b0;
      result_q <= 12'h000;
      conv_chan_q <= 5'h00;
    end else begin
      if (conv_start) begin
        busy_q <= 1'b1; // [R24]
        conv_chan_q <= chan;
        eoc_q <= 1'b0;
      end else if (conv_done) begin
        busy_q <= 1'b0; // [R24]
      end else if (wr_ctrl && I_WDATA[aio_pkg::CTL_CLRBUSY]) begin
        busy_q <= 1'b0; // [R18]
      end
      if (conv_done) begin
        result_q <= conv_result; // [R22]
        eoc_q <= 1'b1; // [R24]
        if (scan_end) eos_q <= 1'b1; // [R23]
      end else if (wr_iclr) begin
        eoc_q <= 1'b0; // [R8]
        eos_q <= 1'b0; // [R8]
      end
    end
  end

  // outputs all registered
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_RDATA <= aio_pkg::RESET_BYTE;
      O_ACK <= 1'b0;
      O_INT <= 1'b0;
      O_MUX_CHAN <= 5'h00;
      O_MUX_VALID <= 1'b0;
      O_GAIN <= 2'h0;
    end else begin
      O_RDATA <= (I_MRD && hit) ? rdata_d : aio_pkg::RESET_BYTE;
      O_ACK <= (I_MRD || I_MWR) && hit;
      O_INT <= (eoc_q && ctrl_q[aio_pkg::CTL_EOC_IE]) ||
               (eos_q && ctrl_q[aio_pkg::CTL_EOS_IE]); // [R8]
      O_MUX_CHAN <= chan; // [R2]
      O_MUX_VALID <= (chan <= chan_max); // [R21]
      O_GAIN <= chan_gain_q[aio_pkg::GAIN_LSB +: aio_pkg::GAIN_W]; // [R16]
    end
  end
endmodule

/* File: test/aio_ctrl_checker.sv */
// Purpose: port-level checker for the analog i/o board control logic
// Assumes: one clock, host strobes are one-cycle pulses
// Notes: sees only top-level ports, attached by bind below
`timescale 1ns/1ps
module aio_ctrl_checker (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic [15:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_MWR,
  input wire logic I_MRD,
  input wire logic [15:0] I_BASE,
  input wire logic [7:0] O_RDATA,
  input wire logic O_ACK,
  input wire logic O_INT,
  input wire logic [1:0] O_GAIN,
  input wire logic [11:0] O_DAC0,
  input wire logic [11:0] O_DAC1
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  wire hit = I_ADDR[15:4] == I_BASE[15:4];
  wire [3:0] off = I_ADDR[3:0];
  wire wr = I_MWR && hit;
  wire rd = I_MRD && hit;
  wire [1:0] gain_w = I_WDATA[7:6];
  logic [3:0] nib0_q;
  // own copy of the held nibble, so a lost hold shows up at load
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) nib0_q <= 4'h0;
    else if (wr && off == aio_pkg::OFF_DAC0_LO) nib0_q <= I_WDATA[3:0];
  end
  AST_ACK: assert property ((wr || rd) |=> O_ACK)
    else $error("no ack after a hit access");
  AST_NOACK: assert property (!(wr || rd) |=> !O_ACK)
    else $error("ack without a hit access");
  AST_RDZERO: assert property (!rd |=> O_RDATA == 8'h00)
    else $error("read data outside a read");
  AST_GAIN: assert property (wr && off == aio_pkg::OFF_CHAN |-> ##2 O_GAIN == $past(gain_w, 2))
    else $error("gain not taken from channel write");
  AST_DAC0: assert property (wr && off == aio_pkg::OFF_DAC0_HI
    |=> O_DAC0 == {$past(I_WDATA), nib0_q})
    else $error("dac 0 load wrong");
  AST_DAC1: assert property (wr && off == aio_pkg::OFF_DAC1_HI
    |=> O_DAC1[11:4] == $past(I_WDATA))
    else $error("dac 1 high byte wrong");
  AST_DACHOLD: assert property (!(wr && off == aio_pkg::OFF_DAC0_HI) |=> $stable(O_DAC0))
    else $error("dac 0 moved without high write");
  AST_RESLO: assert property (rd && off == aio_pkg::OFF_RES_LO |=> O_RDATA[7:4] == 4'h0)
    else $error("result low byte upper bits set");
  cover property (rd && off == aio_pkg::OFF_RES_HI);
  cover property ($rose(O_INT));
  cover property (wr && off == aio_pkg::OFF_DAC1_HI);
endmodule

bind aio_ctrl aio_ctrl_checker chk_u (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_MWR(I_MWR), .I_MRD(I_MRD), .I_BASE(I_BASE), .O_RDATA(O_RDATA),
  .O_ACK(O_ACK), .O_INT(O_INT), .O_GAIN(O_GAIN), .O_DAC0(O_DAC0), .O_DAC1(O_DAC1));

/* File: test/analog_src.sv */
// Purpose: analog front end seen by the converter, one fixed level a channel
// Assumes: comparator settles at once
// Notes: no noise, so every result is exact
`timescale 1ns/1ps
module analog_src (
  input wire logic [4:0] i_chan,
  input wire logic i_hold,
  input wire logic [11:0] i_trial,
  output logic o_cmp
);
  logic [4:0] held_q = 5'h00;
  // the converter sees the level caught when hold rises, not the live mux
  always @(posedge i_hold) held_q <= i_chan;
  wire [4:0] src = i_hold ? held_q : i_chan;
  wire [11:0] level = {src, 7'h2B};
  assign o_cmp = level >= i_trial;
endmodule

/* File: test/analog_io_board_control_test.sv */
// Purpose: register-level test of the analog i/o board control logic
// Assumes: default base, expander fitted at first, external trigger idle until its own check
// Notes: pacer base made huge so no tick disturbs the sequence
`timescale 1ns/1ps
module analog_io_board_control_test;
  logic I_CLK, I_RESETN, I_MWR, I_MRD, I_EXPANDED, I_SINGLE_ENDED, I_EXT_TRIG;
  logic [15:0] I_ADDR, I_BASE;
  logic [7:0] I_WDATA, O_RDATA, rd_q;
  logic [3:0] I_PACER_N;
  wire I_CMP;
  logic O_ACK, O_INT, O_MUX_VALID, O_HOLD;
  logic [4:0] O_MUX_CHAN;
  logic [1:0] O_GAIN;
  logic [11:0] O_TRIAL, O_DAC0, O_DAC1;
  int mismatches = 0;
  int n_compared = 0;
  `define CHK(a, b) begin n_compared++; if ((a) !== (b)) err(a, b); end
  aio_ctrl #(.PACER_BASE(1 << 20), .CONV_CYC(24)) dut_u (.I_CLK(I_CLK), .I_RESETN(I_RESETN),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_MWR(I_MWR), .I_MRD(I_MRD), .I_BASE(I_BASE),
    .I_PACER_N(I_PACER_N), .I_EXPANDED(I_EXPANDED), .I_SINGLE_ENDED(I_SINGLE_ENDED),
    .I_EXT_TRIG(I_EXT_TRIG), .I_CMP(I_CMP), .O_RDATA(O_RDATA), .O_ACK(O_ACK), .O_INT(O_INT),
    .O_MUX_CHAN(O_MUX_CHAN), .O_MUX_VALID(O_MUX_VALID), .O_GAIN(O_GAIN), .O_HOLD(O_HOLD),
    .O_TRIAL(O_TRIAL), .O_DAC0(O_DAC0), .O_DAC1(O_DAC1));
  analog_src model_u (.i_chan(O_MUX_CHAN), .i_hold(O_HOLD), .i_trial(O_TRIAL), .o_cmp(I_CMP));
  task automatic err(input logic [11:0] g, input logic [11:0] e);
    mismatches++;
    $display("ERROR t=%0t got %h exp %h", $time, g, e);
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one strobe cycle; read data is taken the cycle after
  task automatic acc(input logic w, input logic [3:0] o, input logic [7:0] d);
    @(negedge I_CLK);
    I_ADDR = {I_BASE[15:4], o};
    I_WDATA = d;
    I_MWR = w;
    I_MRD = !w;
    @(negedge I_CLK);
    I_MWR = 1'b0;
    I_MRD = 1'b0;
    rd_q = O_RDATA;
  endtask
  task automatic wr(input logic [3:0] o, input logic [7:0] d);
    acc(1'b1, o, d);
  endtask
  task automatic rdchk(input logic [3:0] o, input logic [7:0] e);
    acc(1'b0, o, 8'h00);
    `CHK(rd_q, e)
  endtask
  task automatic wait_eoc();
    int k = 0;
    rd_q = 8'h00;
    while (rd_q[7] !== 1'b1 && k < 500) begin
      acc(1'b0, aio_pkg::OFF_CTRL, 8'h00);
      k++;
    end
    if (k == 500) err(12'h000, 12'h080);
  endtask
  // reading the high byte restarts; clear after so the next wait is real
  task automatic conv_chk(input logic [4:0] c);
    logic [11:0] e;
    e = {c, 7'h2B};
    wait_eoc();
    rdchk(aio_pkg::OFF_RES_LO, {4'h0, e[3:0]});
    rdchk(aio_pkg::OFF_RES_HI, e[11:4]);
    wr(aio_pkg::OFF_ICLR, 8'h00);
  endtask
  initial begin
    I_CLK = 1'b0;
    forever #25 I_CLK = ~I_CLK;
  end
  initial begin
    repeat (60000) @(posedge I_CLK);
    mismatches++;
    close_out();
  end
  initial begin
    {I_RESETN, I_MWR, I_MRD, I_EXT_TRIG} = 4'h0;
    {I_EXPANDED, I_SINGLE_ENDED} = 2'h3;
    I_ADDR = 16'h0000;
    I_WDATA = 8'h00;
    I_BASE = aio_pkg::BASE_DEFAULT;
    I_PACER_N = 4'h0;
    repeat (20) @(negedge I_CLK);
    I_RESETN = 1'b1;
    rdchk(aio_pkg::OFF_CTRL, aio_pkg::RESET_BYTE);
    rdchk(4'h6, 8'h00);
    for (int g = 0; g < 4; g++) begin
      wr(aio_pkg::OFF_CHAN, {2'(g), 6'h25});
      rdchk(aio_pkg::OFF_CHAN, {2'(g), 6'h25});
      `CHK(O_GAIN, 2'(g))
    end
    wr(aio_pkg::OFF_CHAN, 8'h05);
    @(negedge I_CLK);
    `CHK(O_MUX_CHAN, 5'h05)
    wr(aio_pkg::OFF_CTRL, 8'h21);
    rdchk(aio_pkg::OFF_CTRL, 8'h29);
    repeat (4) @(negedge I_CLK);
    `CHK(O_HOLD, 1'b1)
    wait_eoc();
    `CHK(O_INT, 1'b1)
    `CHK(O_TRIAL, 12'h2AB)
    `CHK(O_HOLD, 1'b0)
    conv_chk(5'h05);
    @(negedge I_CLK);
    `CHK(O_INT, 1'b0)
    acc(1'b0, aio_pkg::OFF_CTRL, 8'h00);
    `CHK(rd_q[3], 1'b1)
    wr(aio_pkg::OFF_CHAN, 8'h09);
    conv_chk(5'h05);
    conv_chk(5'h09);
    wait_eoc();
    wr(aio_pkg::OFF_ICLR, 8'h00);
    wr(aio_pkg::OFF_LAST, 8'h02);
    wr(aio_pkg::OFF_CHAN, 8'h00);
    wr(aio_pkg::OFF_CTRL, 8'h13);
    for (int i = 0; i < 3; i++) begin
      wait_eoc();
      `CHK(rd_q[6], 1'(i == 2))
      `CHK(O_INT, 1'(i == 2))
      rdchk(aio_pkg::OFF_CHAN, (i == 2) ? 8'h00 : 8'(i + 1));
      conv_chk(5'(i));
    end
    wr(aio_pkg::OFF_DAC0_LO, 8'h0A);
    `CHK(O_DAC0, aio_pkg::RESET_DAC)
    wr(aio_pkg::OFF_DAC0_HI, 8'hBC);
    `CHK(O_DAC0, 12'hBCA)
    wr(aio_pkg::OFF_DAC1_LO, 8'h07);
    wr(aio_pkg::OFF_DAC1_HI, 8'h31);
    `CHK(O_DAC1, 12'h317)
    `CHK(O_DAC0, 12'hBCA)
    // stop scanning, then fewer fitted inputs
    wait_eoc();
    wr(aio_pkg::OFF_CTRL, 8'h00);
    wr(aio_pkg::OFF_ICLR, 8'h00);
    {I_EXPANDED, I_SINGLE_ENDED} = 2'h0;
    wr(aio_pkg::OFF_CHAN, 8'h09);
    @(negedge I_CLK);
    `CHK(O_MUX_VALID, 1'b0)
    wr(aio_pkg::OFF_CHAN, 8'h07);
    @(negedge I_CLK);
    `CHK(O_MUX_VALID, 1'b1)
    // external trigger mode: a result read must not restart
    wr(aio_pkg::OFF_CTRL, 8'h05);
    conv_chk(5'h07);
    acc(1'b0, aio_pkg::OFF_CTRL, 8'h00);
    `CHK(rd_q[3], 1'b0)
    @(negedge I_CLK);
    I_EXT_TRIG = 1'b1;
    @(negedge I_CLK);
    I_EXT_TRIG = 1'b0;
    conv_chk(5'h07);
    // pacer start: shortest period, no result read in between
    wr(aio_pkg::OFF_CTRL, 8'h01);
    wait_eoc();
    wr(aio_pkg::OFF_ICLR, 8'h00);
    I_PACER_N = 4'hA;
    conv_chk(5'h07);
    close_out();
  end
endmodule
